// ===== design/int_unit_pkg.sv
package int_unit_pkg;

   // source bit positions, shared by flag and enable registers
   localparam int SRC_COUNT       = 4;
   localparam int BIT_COUNTER_OVF = 0;
   localparam int BIT_EXT_PIN     = 1;
   localparam int BIT_SERIAL_DONE = 2;
   localparam int BIT_SECOND_TMR  = 3;

   // register widths and reset values
   localparam int             REG_W      = 8;
   localparam int             PC_W       = 12;
   localparam logic [3:0]     FLAG_RESET = 4'h0;
   localparam logic [3:0]     ENAB_RESET = 4'h0;
   localparam logic [3:0]     HI_ZERO    = 4'h0;

   // fixed fetch vectors
   localparam logic [11:0]    HW_VECTOR  = 12'h001;
   localparam logic [11:0]    SW_VECTOR  = 12'h002;
   localparam logic [11:0]    PC_RESET   = 12'h000;

   // instruction events reported by the core sequencer
   typedef struct packed {
      logic global_int_on_instr;
      logic global_int_off_instr;
      logic int_return_instr;
      logic sw_int_instr;
   } instr_events_s;

   // fetch redirection request handed to the core
   typedef struct packed {
      logic        redirect;
      logic [11:0] vector;
      logic        push;
      logic [11:0] return_addr;
   } redirect_s;

endpackage : int_unit_pkg

// ===== design/mcu_interrupt_unit.sv
`timescale 1ns/1ps
module mcu_interrupt_unit (
   input  wire logic                        clock_i,
   input  wire logic                        reset_i,
   input  wire logic                        counter_ovf_i,
   input  wire logic                        ext_pin_i,
   input  wire logic                        serial_done_i,
   input  wire logic                        second_timer_i,
   input  wire int_unit_pkg::instr_events_s instr_i,
   input  wire logic                        fetch_i,
   input  wire logic [11:0]                 fetch_pc_i,
   input  wire logic                        flag_wr_i,
   input  wire logic [7:0]                  flag_wdata_i,
   input  wire logic                        enable_wr_i,
   input  wire logic [7:0]                  enable_wdata_i,
   output logic [7:0]                       int_flag_rd_o,
   output logic [7:0]                       int_enable_rd_o,
   output logic                             global_int_o,
   output int_unit_pkg::redirect_s          redirect_o
);

   logic [3:0]  int_flag_reg;
   logic [3:0]  int_enable_reg;
   logic        global_en_reg;
   logic        ext_meta_reg;
   logic        ext_sync_reg;
   logic        ext_prev_reg;
   logic [3:0]  src_event;
   logic        hw_take;
   logic        sw_take;
   logic [3:0]  int_flag_next;

   // the pin is asynchronous, so it is synchronised before any edge detection
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_meta_reg <= ext_pin_i;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end

   // gather source events into flag positions; pin fires on falling edge
   always_comb begin
      src_event = '0;
      src_event[int_unit_pkg::BIT_COUNTER_OVF] = counter_ovf_i;
      src_event[int_unit_pkg::BIT_EXT_PIN]     = ext_prev_reg & ~ext_sync_reg;
      src_event[int_unit_pkg::BIT_SERIAL_DONE] = serial_done_i;
      src_event[int_unit_pkg::BIT_SECOND_TMR]  = second_timer_i;
   end

   // a hardware take needs a pending enabled flag and the global enable
   assign hw_take = fetch_i & global_en_reg & (|(int_flag_reg & int_enable_reg));
   assign sw_take = fetch_i & global_en_reg & instr_i.sw_int_instr & ~hw_take;

   // software write loads flags, but a source event in the same cycle wins
   always_comb begin
      int_flag_next = int_flag_reg;
      if (flag_wr_i) begin
         int_flag_next = flag_wdata_i[int_unit_pkg::SRC_COUNT-1:0];
      end
      int_flag_next = int_flag_next | src_event;
   end

   // request flags: sticky until software clears them
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         int_flag_reg <= int_unit_pkg::FLAG_RESET;
      end else begin
         int_flag_reg <= int_flag_next;
      end
   end

   // per-source enables
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         int_enable_reg <= int_unit_pkg::ENAB_RESET;
      end else if (enable_wr_i) begin
         int_enable_reg <= enable_wdata_i[int_unit_pkg::SRC_COUNT-1:0];
      end
   end

   // global enable: accepting an interrupt clears it, so the handler is not re-entered
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         global_en_reg <= 1'b0;
      end else if (hw_take | sw_take) begin
         global_en_reg <= 1'b0;
      end else if (instr_i.global_int_on_instr | instr_i.int_return_instr) begin
         global_en_reg <= 1'b1;
      end else if (instr_i.global_int_off_instr) begin
         global_en_reg <= 1'b0;
      end
   end

   // registered read views; unused upper bits read zero
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         int_flag_rd_o   <= '0;
         int_enable_rd_o <= '0;
         global_int_o    <= 1'b0;
      end else begin
         int_flag_rd_o   <= {int_unit_pkg::HI_ZERO, int_flag_next & int_enable_reg};
         int_enable_rd_o <= {int_unit_pkg::HI_ZERO, int_enable_reg};
         global_int_o    <= global_en_reg;
      end
   end

   // redirect pulse to the fetch logic, one cycle per accepted interrupt
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         redirect_o <= '0;
      end else begin
         redirect_o.redirect    <= hw_take | sw_take;
         redirect_o.push        <= hw_take | sw_take;
         redirect_o.return_addr <= fetch_pc_i;
         redirect_o.vector      <= hw_take ? int_unit_pkg::HW_VECTOR
                                 : sw_take ? int_unit_pkg::SW_VECTOR
                                 : int_unit_pkg::PC_RESET;
      end
   end

   property p_hw_vector;
      @(posedge clock_i) disable iff (reset_i)
      hw_take |=> redirect_o.redirect && redirect_o.vector == int_unit_pkg::HW_VECTOR;
   endproperty
   a_hw_vector: assert property (p_hw_vector) else $error("hw vector wrong");

   property p_sw_vector;
      @(posedge clock_i) disable iff (reset_i)
      (fetch_i && global_en_reg && instr_i.sw_int_instr && !(|(int_flag_reg & int_enable_reg)))
         |=> redirect_o.vector == int_unit_pkg::SW_VECTOR && redirect_o.push;
   endproperty
   a_sw_vector: assert property (p_sw_vector) else $error("sw vector wrong");

   property p_set_wins;
      @(posedge clock_i) disable iff (reset_i)
      counter_ovf_i |=> int_flag_reg[int_unit_pkg::BIT_COUNTER_OVF];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag not set");

   // a synchronised falling edge on the pin must land in its flag
   property p_pin_flag;
      @(posedge clock_i) disable iff (reset_i)
      (ext_prev_reg && !ext_sync_reg) |=> int_flag_reg[int_unit_pkg::BIT_EXT_PIN];
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("pin edge not latched");

   // a write with no event in the same cycle loads the written bit, so a 0 clears
   property p_flag_write;
      @(posedge clock_i) disable iff (reset_i)
      (flag_wr_i && !counter_ovf_i)
         |=> int_flag_reg[int_unit_pkg::BIT_COUNTER_OVF] == $past(flag_wdata_i[int_unit_pkg::BIT_COUNTER_OVF]);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("flag write lost");

   property p_sticky;
      @(posedge clock_i) disable iff (reset_i)
      (int_flag_reg[int_unit_pkg::BIT_SERIAL_DONE] && !flag_wr_i) |=> int_flag_reg[int_unit_pkg::BIT_SERIAL_DONE];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

   property p_read_and;
      @(posedge clock_i) disable iff (reset_i)
      ##1 int_flag_rd_o == {int_unit_pkg::HI_ZERO, int_flag_reg & $past(int_enable_reg)};
   endproperty
   a_read_and: assert property (p_read_and) else $error("flag read not masked");

   // enable view follows the enables one cycle later, upper bits zero
   property p_enable_view;
      @(posedge clock_i) disable iff (reset_i)
      ##1 int_enable_rd_o == {int_unit_pkg::HI_ZERO, $past(int_enable_reg)};
   endproperty
   a_enable_view: assert property (p_enable_view) else $error("enable read wrong");

   // the on instruction arms the global enable unless a take wins the cycle
   property p_on_instr;
      @(posedge clock_i) disable iff (reset_i)
      (instr_i.global_int_on_instr && !hw_take && !sw_take) |=> global_en_reg;
   endproperty
   a_on_instr: assert property (p_on_instr) else $error("on did not enable");

   property p_on;
      @(posedge clock_i) disable iff (reset_i)
      (instr_i.int_return_instr && !hw_take && !sw_take) |=> global_en_reg;
   endproperty
   a_on: assert property (p_on) else $error("return did not enable");

   property p_off;
      @(posedge clock_i) disable iff (reset_i)
      (instr_i.global_int_off_instr && !instr_i.global_int_on_instr && !instr_i.int_return_instr)
         |=> !global_en_reg;
   endproperty
   a_off: assert property (p_off) else $error("off did not disable");

   property p_take_off;
      @(posedge clock_i) disable iff (reset_i)
      hw_take |=> !global_en_reg ##1 !global_int_o;
   endproperty
   a_take_off: assert property (p_take_off) else $error("take kept enable");

   // a software take also drops the global enable
   property p_sw_off;
      @(posedge clock_i) disable iff (reset_i)
      sw_take |=> !global_en_reg ##1 !global_int_o;
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("sw take kept enable");

   // with no enabled flag and no software request a fetch is never redirected
   property p_no_take;
      @(posedge clock_i) disable iff (reset_i)
      (fetch_i && !instr_i.sw_int_instr && !(|(int_flag_reg & int_enable_reg))) |=> !redirect_o.redirect;
   endproperty
   a_no_take: assert property (p_no_take) else $error("take while disabled");

endmodule : mcu_interrupt_unit

// ===== verif/core_fetch_model.sv
`timescale 1ns/1ps
// stand-in for the core sequencer: one fetch every other clock, jumps on redirect
module core_fetch_model (
   input  wire logic                    clock_i,
   input  wire logic                    reset_i,
   input  wire int_unit_pkg::redirect_s redirect_i,
   output logic                         fetch_o,
   output logic [11:0]                  fetch_pc_o
);
   // a slow fetch rate also shows that a pending request waits for a fetch slot
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         fetch_o    <= 1'b0;
         fetch_pc_o <= 12'h000;
      end else begin
         fetch_o <= ~fetch_o;
         if (redirect_i.redirect) fetch_pc_o <= redirect_i.vector;
         else if (fetch_o) fetch_pc_o <= fetch_pc_o + 12'h001;
      end
   end
endmodule : core_fetch_model

// ===== verif/test_mcu_interrupt_unit.sv
`timescale 1ns/1ps
module test_mcu_interrupt_unit;
   logic                        clock_i, reset_i, ovf, pin, ser, tmr, fetch, f_wr, e_wr, glob;
   logic [11:0]                 pc;
   logic [7:0]                  f_wd, e_wd, f_rd, e_rd;
   int_unit_pkg::instr_events_s instr;
   int_unit_pkg::redirect_s     rd;
   int                          failures = 0, checks = 0, cycles = 0;
   typedef struct { logic [3:0] src; logic [3:0] en; logic [7:0] exp; } row_s;
   row_s rows [7] = '{'{4'h1, 4'h1, 8'h01}, '{4'h2, 4'h2, 8'h02}, '{4'h4, 4'h4, 8'h04},
      '{4'h8, 4'h8, 8'h08}, '{4'hF, 4'h5, 8'h05}, '{4'hF, 4'h0, 8'h00}, '{4'h6, 4'hF, 8'h06}};
   mcu_interrupt_unit mcu_interrupt_unit_i (.clock_i(clock_i), .reset_i(reset_i), .counter_ovf_i(ovf),
      .ext_pin_i(pin), .serial_done_i(ser), .second_timer_i(tmr), .instr_i(instr), .fetch_i(fetch),
      .fetch_pc_i(pc), .flag_wr_i(f_wr), .flag_wdata_i(f_wd), .enable_wr_i(e_wr), .enable_wdata_i(e_wd),
      .int_flag_rd_o(f_rd), .int_enable_rd_o(e_rd), .global_int_o(glob), .redirect_o(rd));
   core_fetch_model core_fetch_model_i (.clock_i(clock_i), .reset_i(reset_i), .redirect_i(rd),
      .fetch_o(fetch), .fetch_pc_o(pc));
   // 5 ns clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // run is under two hundred cycles, so this only trips on a hang
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         finish_test();
      end
   end
   task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // the pin idles high and fires on its falling edge
   task automatic pulse(logic [3:0] s);
      {tmr, ser, pin, ovf} <= {s[3], s[2], ~s[1], s[0]};
      @(posedge clock_i);
      {tmr, ser, pin, ovf} <= 4'b0010;
      repeat (5) @(posedge clock_i);
   endtask : pulse
   task automatic wr(logic to_flag, logic [7:0] d);
      if (to_flag) {f_wr, f_wd} <= {1'b1, d};
      else {e_wr, e_wd} <= {1'b1, d};
      @(posedge clock_i);
      {f_wr, e_wr} <= 2'b00;
      repeat (2) @(posedge clock_i);
   endtask : wr
   task automatic ins(logic [3:0] v);
      instr <= v;
      @(posedge clock_i);
      instr <= '0;
      repeat (3) @(posedge clock_i);
   endtask : ins
   // bounded wait for the redirect pulse, then realign to an edge
   task automatic expect_jump(logic [11:0] v);
      int n;
      n = 0;
      #1;
      while (rd.redirect !== 1'b1 && n < 20) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      check("redirect", {11'h000, rd.redirect}, 12'h001);
      check("vector", rd.vector, v);
      check("push", {11'h000, rd.push}, 12'h001);
      // the model stepped past the taken fetch on the take edge
      check("return", rd.return_addr, pc - 12'h001);
      @(posedge clock_i);
   endtask : expect_jump
   initial begin
      {reset_i, ovf, pin, ser, tmr, f_wr, e_wr, f_wd, e_wd} = {1'b1, 4'b0010, 2'b00, 16'h0000};
      instr = '0;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      #1;
      check("flag", {4'h0, f_rd}, 12'h000);
      check("enable", {4'h0, e_rd}, 12'h000);
      check("global", {11'h000, glob}, 12'h000);
      @(posedge clock_i);
      // global enable stays off here, so flags only latch and mask
      foreach (rows[i]) begin
         wr(1'b1, 8'h00);
         wr(1'b0, {4'hF, rows[i].en});
         pulse(rows[i].src);
         check("flag", {4'h0, f_rd}, {4'h0, rows[i].exp});
         check("enable", {4'h0, e_rd}, {8'h00, rows[i].en});
      end
      $display("test rows done");
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h01);
      ins(4'b1000);
      check("global", {11'h000, glob}, 12'h001);
      // the redirect stands one cycle, so the watch starts right after the event
      ovf <= 1'b1;
      @(posedge clock_i);
      ovf <= 1'b0;
      expect_jump(int_unit_pkg::HW_VECTOR);
      repeat (2) @(posedge clock_i);
      check("global", {11'h000, glob}, 12'h000);
      check("flag", {4'h0, f_rd}, 12'h001);
      // return re-arms global, and the uncleared flag fires again
      instr <= 4'b0010;
      @(posedge clock_i);
      instr <= '0;
      expect_jump(int_unit_pkg::HW_VECTOR);
      $display("test hardware jump done");
      // a clear and an overflow in one cycle: the set wins
      {f_wr, f_wd, ovf} <= {1'b1, 8'h00, 1'b1};
      @(posedge clock_i);
      {f_wr, ovf} <= 2'b00;
      repeat (2) @(posedge clock_i);
      check("flag", {4'h0, f_rd}, 12'h001);
      wr(1'b1, 8'h00);
      check("flag", {4'h0, f_rd}, 12'h000);
      ins(4'b1000);
      // place the software pulse on a fetch cycle
      do begin
         @(posedge clock_i);
         #1;
      end while (fetch !== 1'b0);
      @(posedge clock_i);
      instr <= 4'b0001;
      @(posedge clock_i);
      instr <= '0;
      expect_jump(int_unit_pkg::SW_VECTOR);
      @(posedge clock_i);
      check("global", {11'h000, glob}, 12'h000);
      ins(4'b1000);
      ins(4'b0100);
      check("global", {11'h000, glob}, 12'h000);
      $display("test software jump done");
      // arm the global enable so the reset has something to clear
      ins(4'b1000);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      check("enable", {4'h0, e_rd}, 12'h000);
      check("global", {11'h000, glob}, 12'h000);
      $display("test reset done");
      finish_test();
   end
endmodule : test_mcu_interrupt_unit
